// [rtl/dicp_pkg.sv]
package dicp_pkg;

    localparam int NUM_CHAN = 9;
    localparam int NUM_REGS = 32;

    // =====================================================================
    // Address map
    localparam logic [4:0] SLAVE_PREFIX = 5'h16;
    localparam logic [4:0] MODE_BASE = 5'h01;
    localparam logic [4:0] CODE_BASE = 5'h11;
    localparam logic [6:0] CODE_BASE7 = 7'h11;
    localparam logic [6:0] CODE_LAST7 = 7'h19;
    localparam logic [4:0] SHUT_ADDR = 5'h1B;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // =====================================================================
    // Clear modes
    localparam logic [1:0] MODE_IGNORE = 2'h0;
    localparam logic [1:0] MODE_SHUTTER = 2'h1;
    localparam logic [1:0] MODE_GATE = 2'h2;
    localparam logic [1:0] MODE_RESET = 2'h3;

    // =====================================================================
    // Bit counting
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [1:0] RD_ZERO_IDX = 2'h2;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} dicp_st_t;
    typedef enum logic [1:0] {K_ADDR, K_CMD, K_HI, K_LO} dicp_kind_t;

    typedef struct packed {
        dicp_st_t st;
        dicp_kind_t kind;
        logic rdMode;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] hiByte;
        logic [6:0] regAddr;
        logic [1:0] rdIdx;
        logic [7:0] txShift;
        logic sdaOe;
        logic sclPrev;
        logic sdaPrev;
        logic clearPrev;
        logic txnClr;
        logic [NUM_REGS-1:0][15:0] regs;
    } dicp_state_t;

    typedef struct packed {
        logic [13:0] code;
        logic off;
    } dicp_chan_t;

endpackage

// [rtl/dicp_sync2.sv]
`timescale 1ns/100ps
module dicp_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule

// [rtl/dicp_chan.sv]
`timescale 1ns/100ps
module dicp_chan (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clearLvl,
    input wire logic [1:0] clearMode,
    input wire logic [13:0] code,
    input wire logic [13:0] shutterCode,
    output logic [13:0] dacCode,
    output logic dacOff
);
    dicp_pkg::dicp_chan_t s_r;
    dicp_pkg::dicp_chan_t s_nxt;

    always_comb begin
        s_nxt.code = code;
        s_nxt.off = 1'b0;
        if (clearLvl && clearMode == dicp_pkg::MODE_SHUTTER) begin
            s_nxt.code = shutterCode;
        end
        if (clearLvl && clearMode == dicp_pkg::MODE_GATE) begin
            s_nxt.off = 1'b1;
        end
    end

    // Release simply falls back to the stored code, latest write included
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dacCode = s_r.code;
    assign dacOff = s_r.off;

    a_gate_off: assert property (@(posedge clk) disable iff (!rstn)
        (clearLvl && clearMode == dicp_pkg::MODE_GATE) |=> dacOff)
        else $error("gate channel not off under clear");
    a_shutter_code: assert property (@(posedge clk) disable iff (!rstn)
        (clearLvl && clearMode == dicp_pkg::MODE_SHUTTER) |=> dacCode == $past(shutterCode))
        else $error("shutter channel not on shutter code");
    a_release_restore: assert property (@(posedge clk) disable iff (!rstn)
        (!clearLvl && $past(clearLvl) && clearMode[1] != clearMode[0]) |=> dacCode == $past(code) && !dacOff)
        else $error("channel did not restore code on release");
endmodule

// [rtl/dicp_top.sv]
`timescale 1ns/100ps
module dicp_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic modeTriggerInput,
    input wire logic addrSel0,
    input wire logic addrSel1,
    output logic [8:0][13:0] dacCode,
    output logic [8:0] dacOff
);
    // =====================================================================
    // Reset release and input sampling
    logic [1:0] rstPipe_r;
    logic rstSync;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe_r <= 2'h0;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstSync = rstPipe_r[1];

    logic [4:0] pinSync;
    logic sclS;
    logic sdaS;
    logic clr;
    logic [1:0] addrPins;

    dicp_sync2 #(.W(5)) u_sync (
        .clk(clk),
        .rstn(rstSync),
        .din({addrSel1, addrSel0, modeTriggerInput, sdaIn, scl}),
        .dout(pinSync)
    );
    assign sclS = pinSync[0];
    assign sdaS = pinSync[1];
    assign clr = pinSync[2];
    assign addrPins = pinSync[4:3];

    // =====================================================================
    // Bus events
    dicp_pkg::dicp_state_t s_r;
    dicp_pkg::dicp_state_t s_nxt;

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic clearRise;
    logic byteDone;
    logic addrHit;
    logic isCode;
    logic [6:0] chanOff;
    logic discardNow;
    logic commitNow;
    logic [15:0] rdWord;

    assign sclRise = sclS && !s_r.sclPrev;
    assign sclFall = !sclS && s_r.sclPrev;
    // Sampled after two flops, so SDA edges with SCL high are clean
    assign startCond = sclS && s_r.sclPrev && s_r.sdaPrev && !sdaS;
    assign stopCond = sclS && s_r.sclPrev && !s_r.sdaPrev && sdaS;
    assign clearRise = clr && !s_r.clearPrev;
    assign byteDone = sclFall && s_r.st == dicp_pkg::ST_RX && s_r.bitCnt == dicp_pkg::BITS_PER_BYTE;
    assign addrHit = s_r.shift[7:1] == {dicp_pkg::SLAVE_PREFIX, addrPins};
    assign isCode = s_r.regAddr >= dicp_pkg::CODE_BASE7 && s_r.regAddr <= dicp_pkg::CODE_LAST7;
    assign chanOff = s_r.regAddr - dicp_pkg::CODE_BASE7;
    // Reset-mode channel refuses codes from a transaction that saw clear
    assign discardNow = isCode && (s_r.txnClr || clr)
        && s_r.regs[dicp_pkg::MODE_BASE + chanOff[4:0]][1:0] == dicp_pkg::MODE_RESET;
    assign commitNow = byteDone && s_r.kind == dicp_pkg::K_LO;
    assign rdWord = (s_r.regAddr[6:5] == 2'h0) ? s_r.regs[s_r.regAddr[4:0]] : dicp_pkg::REG_RESET;

    function automatic logic [7:0] txByteOf(input logic [1:0] idx, input logic [15:0] word);
        logic [7:0] b;
        b = 8'h00;
        if (idx == 2'h0) begin
            b = word[15:8];
        end else if (idx == 2'h1) begin
            b = word[7:0];
        end
        return b;
    endfunction

    // =====================================================================
    // Protocol engine
    always_comb begin
        logic [7:0] nb;
        nb = 8'h00;
        s_nxt = s_r;
        s_nxt.sclPrev = sclS;
        s_nxt.sdaPrev = sdaS;
        s_nxt.clearPrev = clr;
        // Clear only watches, never steers the engine
        if (clr && s_r.st != dicp_pkg::ST_IDLE) begin
            s_nxt.txnClr = 1'b1;
        end
        for (int ch = 0; ch < dicp_pkg::NUM_CHAN; ch++) begin
            if (clearRise && s_r.regs[dicp_pkg::MODE_BASE + 5'(ch)][1:0] == dicp_pkg::MODE_RESET) begin
                s_nxt.regs[dicp_pkg::CODE_BASE + 5'(ch)] = dicp_pkg::REG_RESET;
            end
        end
        if (stopCond) begin
            s_nxt.st = dicp_pkg::ST_IDLE;
            s_nxt.sdaOe = 1'b0;
            s_nxt.rdMode = 1'b0;
        end else if (startCond) begin
            s_nxt.st = dicp_pkg::ST_RX;
            s_nxt.kind = dicp_pkg::K_ADDR;
            s_nxt.bitCnt = 4'h0;
            s_nxt.sdaOe = 1'b0;
            s_nxt.rdMode = 1'b0;
            if (s_r.st == dicp_pkg::ST_IDLE) begin
                s_nxt.txnClr = clr;
            end
        end else begin
            unique case (s_r.st)
                dicp_pkg::ST_IDLE: begin
                end
                dicp_pkg::ST_RX: begin
                    if (sclRise && s_r.bitCnt != dicp_pkg::BITS_PER_BYTE) begin
                        s_nxt.shift = {s_r.shift[6:0], sdaS};
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                    end else if (byteDone) begin
                        s_nxt.st = dicp_pkg::ST_ACK;
                        s_nxt.sdaOe = 1'b1;
                        unique case (s_r.kind)
                            dicp_pkg::K_ADDR: begin
                                s_nxt.rdMode = s_r.shift[0];
                                s_nxt.kind = dicp_pkg::K_CMD;
                                s_nxt.rdIdx = 2'h0;
                                if (!addrHit) begin
                                    s_nxt.st = dicp_pkg::ST_IDLE;
                                    s_nxt.sdaOe = 1'b0;
                                end
                            end
                            dicp_pkg::K_CMD: begin
                                s_nxt.regAddr = s_r.shift[7:1];
                                s_nxt.kind = dicp_pkg::K_HI;
                            end
                            dicp_pkg::K_HI: begin
                                s_nxt.hiByte = s_r.shift;
                                s_nxt.kind = dicp_pkg::K_LO;
                            end
                            dicp_pkg::K_LO: begin
                                // Commit lands in the ack slot, outputs stay still mid-byte
                                if (s_r.regAddr[6:5] == 2'h0 && !discardNow) begin
                                    s_nxt.regs[s_r.regAddr[4:0]] = {s_r.hiByte, s_r.shift};
                                end
                                s_nxt.kind = dicp_pkg::K_CMD;
                            end
                        endcase
                    end
                end
                dicp_pkg::ST_ACK: begin
                    if (sclFall) begin
                        s_nxt.bitCnt = 4'h0;
                        s_nxt.sdaOe = 1'b0;
                        s_nxt.st = dicp_pkg::ST_RX;
                        if (s_r.rdMode) begin
                            nb = txByteOf(s_r.rdIdx, rdWord);
                            s_nxt.st = dicp_pkg::ST_TX;
                            s_nxt.txShift = nb;
                            s_nxt.sdaOe = !nb[7];
                        end
                    end
                end
                dicp_pkg::ST_TX: begin
                    if (sclFall) begin
                        if (s_r.bitCnt == dicp_pkg::LAST_TX_BIT) begin
                            s_nxt.sdaOe = 1'b0;
                            s_nxt.st = dicp_pkg::ST_TXACK;
                            if (s_r.rdIdx != dicp_pkg::RD_ZERO_IDX) begin
                                s_nxt.rdIdx = s_r.rdIdx + 2'h1;
                            end
                        end else begin
                            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                            s_nxt.txShift = {s_r.txShift[6:0], 1'b0};
                            s_nxt.sdaOe = !s_r.txShift[6];
                        end
                    end
                end
                dicp_pkg::ST_TXACK: begin
                    if (sclRise && sdaS) begin
                        s_nxt.st = dicp_pkg::ST_IDLE;
                    end else if (sclFall) begin
                        nb = txByteOf(s_r.rdIdx, rdWord);
                        s_nxt.st = dicp_pkg::ST_TX;
                        s_nxt.bitCnt = 4'h0;
                        s_nxt.txShift = nb;
                        s_nxt.sdaOe = !nb[7];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            s_r <= '0;
            s_r.sclPrev <= 1'b1;
            s_r.sdaPrev <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sdaOe = s_r.sdaOe;
    assign sdaOut = 1'b0;

    // =====================================================================
    // Channel output stages
    for (genvar g = 0; g < dicp_pkg::NUM_CHAN; g++) begin : g_chan
        dicp_chan u_chan (
            .clk(clk),
            .rstn(rstSync),
            .clearLvl(clr),
            .clearMode(s_r.regs[dicp_pkg::MODE_BASE + 5'(g)][1:0]),
            .code(s_r.regs[dicp_pkg::CODE_BASE + 5'(g)][15:2]),
            .shutterCode(s_r.regs[dicp_pkg::SHUT_ADDR][15:2]),
            .dacCode(dacCode[g]),
            .dacOff(dacOff[g])
        );

        // Per channel, since each follows its own clear mode
        a_clear_zero: assert property (@(posedge clk) disable iff (!rstSync)
            (clearRise && s_r.regs[dicp_pkg::MODE_BASE + 5'(g)][1:0] == dicp_pkg::MODE_RESET)
            |=> s_r.regs[dicp_pkg::CODE_BASE + 5'(g)] == dicp_pkg::REG_RESET)
            else $error("reset-mode code not zeroed");
        a_mode_kept: assert property (@(posedge clk) disable iff (!rstSync)
            (clearRise && !commitNow)
            |=> s_r.regs[dicp_pkg::MODE_BASE + 5'(g)] == $past(s_r.regs[dicp_pkg::MODE_BASE + 5'(g)]))
            else $error("clear disturbed a mode register");
    end

    // =====================================================================
    // Checks
    a_stop_ends: assert property (@(posedge clk) disable iff (!rstSync)
        stopCond |=> s_r.st == dicp_pkg::ST_IDLE && !s_r.sdaOe)
        else $error("stop did not end transaction");
    a_stop_no_commit: assert property (@(posedge clk) disable iff (!rstSync)
        (stopCond && !clearRise) |=> s_r.regs == $past(s_r.regs))
        else $error("registers changed on stop");
    a_restart_discard: assert property (@(posedge clk) disable iff (!rstSync)
        (startCond && !clearRise) |=> s_r.regs == $past(s_r.regs) ##1 s_r.kind == dicp_pkg::K_ADDR)
        else $error("restart changed registers");
    a_commit_in_ack: assert property (@(posedge clk) disable iff (!rstSync)
        commitNow |=> s_r.st == dicp_pkg::ST_ACK && s_r.sdaOe && s_r.kind == dicp_pkg::K_CMD)
        else $error("commit outside acknowledge");
    a_reset_discard: assert property (@(posedge clk) disable iff (!rstSync)
        (commitNow && discardNow && !clearRise) |=> s_r.regs == $past(s_r.regs))
        else $error("reset-mode code write not discarded");
    a_idle_quiet: assert property (@(posedge clk) disable iff (!rstSync)
        (s_r.st == dicp_pkg::ST_IDLE) |-> !s_r.sdaOe)
        else $error("SDA pulled while idle");
    a_oe_where: assert property (@(posedge clk) disable iff (!rstSync)
        s_r.sdaOe |-> (s_r.st == dicp_pkg::ST_ACK || s_r.st == dicp_pkg::ST_TX))
        else $error("SDA pulled outside ack or readback");
    a_txack_release: assert property (@(posedge clk) disable iff (!rstSync)
        (s_r.st == dicp_pkg::ST_TXACK) |-> !s_r.sdaOe)
        else $error("SDA held during master acknowledge");
    a_rx_bits: assert property (@(posedge clk) disable iff (!rstSync)
        (s_r.st == dicp_pkg::ST_RX) |-> s_r.bitCnt <= dicp_pkg::BITS_PER_BYTE)
        else $error("receive bit count overran");
    a_tx_bits: assert property (@(posedge clk) disable iff (!rstSync)
        (s_r.st == dicp_pkg::ST_TX) |-> s_r.bitCnt <= dicp_pkg::LAST_TX_BIT)
        else $error("transmit bit count overran");
    a_restart_fresh: assert property (@(posedge clk) disable iff (!rstSync)
        startCond |=> s_r.st == dicp_pkg::ST_RX && s_r.kind == dicp_pkg::K_ADDR
            && s_r.bitCnt == 4'h0 && !s_r.sdaOe)
        else $error("restart did not reopen address byte");
    a_cmd_after_addr: assert property (@(posedge clk) disable iff (!rstSync)
        (byteDone && s_r.kind == dicp_pkg::K_ADDR && addrHit)
        |=> s_r.st == dicp_pkg::ST_ACK && s_r.kind == dicp_pkg::K_CMD)
        else $error("command byte not expected after address");
    a_txn_clear: assert property (@(posedge clk) disable iff (!rstSync)
        (clr && s_r.st != dicp_pkg::ST_IDLE) |=> s_r.txnClr)
        else $error("busy transaction lost its clear mark");
    a_read_hi_first: assert property (@(posedge clk) disable iff (!rstSync)
        (s_r.st == dicp_pkg::ST_ACK && sclFall && s_r.rdMode)
        |=> s_r.st == dicp_pkg::ST_TX && s_r.txShift == $past(rdWord[15:8]))
        else $error("readback did not open with high byte");
    a_nack_idle: assert property (@(posedge clk) disable iff (!rstSync)
        (s_r.st == dicp_pkg::ST_TXACK && sclRise && sdaS) |=> s_r.st == dicp_pkg::ST_IDLE)
        else $error("master refusal did not end readback");
    a_addr_miss: assert property (@(posedge clk) disable iff (!rstSync)
        (byteDone && s_r.kind == dicp_pkg::K_ADDR && !addrHit) |=> s_r.st == dicp_pkg::ST_IDLE && !s_r.sdaOe)
        else $error("foreign address acknowledged");
    a_cmd_lsb: assert property (@(posedge clk) disable iff (!rstSync)
        (byteDone && s_r.kind == dicp_pkg::K_CMD) |=> s_r.regAddr == $past(s_r.shift[7:1]))
        else $error("command address wrong");
    a_extra_zero: assert property (@(posedge clk) disable iff (!rstSync)
        (s_r.st == dicp_pkg::ST_TX && s_r.rdIdx == dicp_pkg::RD_ZERO_IDX) |-> s_r.txShift == 8'h00)
        else $error("extra read byte not zero");
    a_ack_drive: assert property (@(posedge clk) disable iff (!rstSync)
        (s_r.st == dicp_pkg::ST_ACK) |-> s_r.sdaOe)
        else $error("ack not driven");

    c_write: cover property (@(posedge clk) disable iff (!rstSync) commitNow && !discardNow);
    c_third_read: cover property (@(posedge clk) disable iff (!rstSync)
        s_r.st == dicp_pkg::ST_TX && s_r.rdIdx == dicp_pkg::RD_ZERO_IDX);
    c_stop_midbyte: cover property (@(posedge clk) disable iff (!rstSync)
        stopCond && s_r.st == dicp_pkg::ST_RX && s_r.bitCnt != 4'h0);
    c_clear_busy: cover property (@(posedge clk) disable iff (!rstSync)
        clearRise && s_r.st != dicp_pkg::ST_IDLE);
    c_restart: cover property (@(posedge clk) disable iff (!rstSync) startCond && s_r.st != dicp_pkg::ST_IDLE);
endmodule

// [tb/dicp_i2c_master.sv]
`timescale 1ns/100ps
module dicp_i2c_master (
    output logic scl,
    output logic sdaDrv,
    input wire logic sdaLine
);
    // ==========================================
    // Bus master, 800 ns per bit
    // Extra low time per bit, to act as a slow master
    int stretch = 0;

    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    // Repeated START when the clock is low, plain START when idle
    task automatic startC();
        if (scl === 1'b0) begin
            #300 sdaDrv = 1'b1;
            #100 scl = 1'b1;
            #300;
        end
        sdaDrv = 1'b0;
        #300 scl = 1'b0;
    endtask

    task automatic stopC();
        #300 sdaDrv = 1'b0;
        #100 scl = 1'b1;
        #300 sdaDrv = 1'b1;
        #300;
    endtask

    // Data may only move while the clock is low
    task automatic bits(input logic [7:0] b, input int n, output logic [7:0] got);
        got = 8'h00;
        for (int k = 7; k > 7 - n; k--) begin
            #(300 + stretch) sdaDrv = b[k];
            #100 scl = 1'b1;
            #200 got = {got[6:0], sdaLine};
            #200 scl = 1'b0;
        end
    endtask

    task automatic ackClk(input logic drv, output logic seen);
        #(300 + stretch) sdaDrv = drv;
        #100 scl = 1'b1;
        #200 seen = sdaLine;
        #200 scl = 1'b0;
    endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic scl, sdaDrv, sdaOut, sdaOe, ackSeen;
    logic clear = 1'b0;
    logic [1:0] aSel = 2'b00;
    logic [8:0][13:0] dacCode;
    logic [8:0] dacOff;
    logic [7:0] got;
    // Pull-up wire: low when either side pulls
    wire logic sdaLine = sdaDrv & ~sdaOe;
    int err_count = 0;
    int n_compared = 0;
    logic [31:0] rnd = 32'h522a_3d0f;

    always #50 clk = ~clk;

    dicp_top dicp_top_inst (.clk(clk), .resetn(resetn), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .modeTriggerInput(clear), .addrSel0(aSel[0]), .addrSel1(aSel[1]),
        .dacCode(dacCode), .dacOff(dacOff));
    dicp_i2c_master dicp_i2c_master_inst (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

    // ==========================================
    // Helpers
    function automatic logic [31:0] nextRnd(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction

    function automatic logic [7:0] devAddr(input logic rd);
        return {dicp_pkg::SLAVE_PREFIX, aSel[1], aSel[0], rd};
    endfunction

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic sendByte(input logic [7:0] b);
        dicp_i2c_master_inst.bits(b, 8, got);
        dicp_i2c_master_inst.ackClk(1'b1, ackSeen);
        chk("ack", ackSeen, 16'h0000);
    endtask

    task automatic beginW();
        dicp_i2c_master_inst.startC();
        sendByte(devAddr(1'b0));
    endtask

    // Command LSB is random, it must not matter
    task automatic group(input logic [6:0] a, input logic [15:0] v);
        rnd = nextRnd(rnd);
        sendByte({a, rnd[0]});
        sendByte(v[15:8]);
        sendByte(v[7:0]);
    endtask

    task automatic finish();
        dicp_i2c_master_inst.stopC();
        waitClk(4);
    endtask

    task automatic wrReg(input logic [6:0] a, input logic [15:0] v);
        beginW();
        group(a, v);
        finish();
    endtask

    task automatic rdTail(input string what, input logic [15:0] exp);
        logic [7:0] hi, lo, pad;
        dicp_i2c_master_inst.startC();
        sendByte(devAddr(1'b1));
        dicp_i2c_master_inst.bits(8'hFF, 8, hi);
        dicp_i2c_master_inst.ackClk(1'b0, ackSeen);
        dicp_i2c_master_inst.bits(8'hFF, 8, lo);
        dicp_i2c_master_inst.ackClk(1'b0, ackSeen);
        dicp_i2c_master_inst.bits(8'hFF, 8, pad);
        dicp_i2c_master_inst.ackClk(1'b1, ackSeen);
        finish();
        chk(what, {hi, lo}, exp);
        chk("pad byte", {8'h00, pad}, 16'h0000);
    endtask

    task automatic rdCheck(input string what, input logic [6:0] a, input logic [15:0] exp);
        beginW();
        sendByte({a, 1'b1});
        rdTail(what, exp);
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================
    // Watchdog, nearly four times the expected run
    initial begin
        #5_000_000;
        err_count++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        logic [15:0] v1, v2, n2, n4, sh;
        logic [15:0] c [4];
        waitClk(8);
        resetn = 1'b1;
        waitClk(8);
        chk("sdaOe idle", sdaOe, 16'h0000);
        chk("sdaOut", sdaOut, 16'h0000);
        chk("dacCode reset", dacCode[0], 16'h0000);
        chk("dacOff reset", dacOff, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            rnd = nextRnd(rnd);
            aSel = rnd[1:0];
            v1 = rnd[31:16];
            rnd = nextRnd(rnd);
            v2 = {rnd[15:2], 2'b00};
            dicp_i2c_master_inst.stretch = (i == 1) ? 1000 : 0;
            waitClk(8);
            beginW();
            group(7'h0A + 7'(i), v1);
            group(dicp_pkg::CODE_BASE7 + 7'(4 + i), v2);
            finish();
            chk("dacCode", dacCode[4 + i], v2[15:2]);
            rdCheck("storage", 7'h0A + 7'(i), v1);
            rdCheck("code reg", dicp_pkg::CODE_BASE7 + 7'(4 + i), v2);
        end
        dicp_i2c_master_inst.stretch = 0;
        $display("test random writes done");
        dicp_i2c_master_inst.startC();
        dicp_i2c_master_inst.bits({dicp_pkg::SLAVE_PREFIX, aSel[1], ~aSel[0], 1'b0}, 8, got);
        dicp_i2c_master_inst.ackClk(1'b1, ackSeen);
        chk("foreign ack", ackSeen, 16'h0001);
        finish();
        wrReg(7'h25, v1);
        rdCheck("unmapped", 7'h25, 16'h0000);
        $display("test address done");
        // Bit 12 high so the slave is not pulling at the mid-read STOP
        v1 = v1 | 16'h1000;
        wrReg(7'h0A, v1);
        beginW();
        sendByte({7'h0A, 1'b0});
        sendByte(~v1[15:8]);
        dicp_i2c_master_inst.bits(~v1[7:0], 5, got);
        finish();
        rdCheck("after mid stop", 7'h0A, v1);
        beginW();
        sendByte({7'h0A, 1'b0});
        sendByte(~v1[15:8]);
        rdTail("after restart", v1);
        beginW();
        sendByte({7'h0A, 1'b0});
        dicp_i2c_master_inst.startC();
        sendByte(devAddr(1'b1));
        dicp_i2c_master_inst.bits(8'hFF, 3, got);
        finish();
        rdCheck("reread", 7'h0A, v1);
        $display("test aborts done");
        // Channels 0..3 get ignore, shutter, gate, reset
        beginW();
        for (int j = 0; j < 4; j++) begin
            rnd = nextRnd(rnd);
            c[j] = {rnd[15:2], 2'b00};
            group(7'h01 + 7'(j), {14'h0000, 2'(j)});
            group(dicp_pkg::CODE_BASE7 + 7'(j), c[j]);
        end
        // Kept aside, group advances the generator
        sh = {rnd[31:18], 2'b00};
        group(7'h1B, sh);
        finish();
        clear = 1'b1;
        waitClk(8);
        chk("ignore code", dacCode[0], c[0][15:2]);
        chk("shutter code", dacCode[1], sh[15:2]);
        chk("gate off", dacOff[2], 16'h0001);
        chk("reset code", dacCode[3], 16'h0000);
        n2 = {rnd[17:4], 2'b00};
        n4 = {rnd[23:10], 2'b00};
        beginW();
        group(7'h12, n2);
        group(7'h14, n4);
        finish();
        clear = 1'b0;
        waitClk(8);
        chk("shutter return", dacCode[1], n2[15:2]);
        chk("gate return", dacCode[2], c[2][15:2]);
        chk("gate on", dacOff[2], 16'h0000);
        chk("reset held", dacCode[3], 16'h0000);
        rdCheck("mode reg", 7'h04, 16'h0003);
        rdCheck("reset reg", 7'h14, 16'h0000);
        beginW();
        clear = 1'b1;
        waitClk(8);
        clear = 1'b0;
        waitClk(8);
        group(7'h14, n4);
        group(7'h11, n2);
        finish();
        chk("reset after pulse", dacCode[3], 16'h0000);
        chk("ignore after pulse", dacCode[0], n2[15:2]);
        wrReg(7'h14, n4);
        chk("reset reprogram", dacCode[3], n4[15:2]);
        $display("test clear done");
        tally_and_finish();
    end
endmodule
